/* verilog/emac_ctl.sv */
// MAC control and interrupt block: transmit and receive options,
// start/stop with receive FIFO flush, address filter and the seven
// interrupt sources with mask, raw and masked views.
// Assumes the MAC engines run on sys_clk and give one-cycle event
// pulses, while the PHY pin is asynchronous; the software controls are plain ports.
// How it works
// - Transmit options full duplex, auto FCS and padding are independent settings.
// - Receive options bad FCS, multicast and accept-all are independent settings.
// - Stop turns transmitter and receiver off and flushes the receive FIFO.
// - Start turns transmitter and receiver on and empties the receive FIFO.
// - Clear command deasserts the named sticky sources; a same-cycle event keeps its source set.
// - Only enabled pending sources drive the interrupt line.
// - PHY interrupt pulse raises the PHY event source.
// - Management transaction done raises the management source.
// - Length, FCS or PHY receive error raises the receive error source.
// - Frame larger than free receive FIFO space raises overflow source.
// - Transmit frame sent raises the transmit done source.
// - Retry exhaustion or bad stored length raises transmit error source.
// - Receive available source stands while complete frames wait.
// - Raw and masked status views share one bit layout.
// - Packet count rises at good frame end, falls once frame read out.
// - Without accept-all, frames are filtered on the station address.
`timescale 1ns/1ps

module emac_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic flush,
    // Write side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Read side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    // Fill level
    output logic [$clog2(DEPTH):0] free
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire [AW:0] used = wr_ptr - rd_ptr;
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;

    // Full and empty come from the pointer distance
    assign in_ready = (used != (AW+1)'(DEPTH));
    assign out_valid = (used != '0);
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign free = (AW+1)'(DEPTH) - used;

    // Flush only moves pointers; stale words are never seen
    always_ff @(posedge sys_clk) begin
        if (srst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) wr_ptr <= wr_ptr + 1'b1;
            if (do_rd) rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // Storage has no reset
    always_ff @(posedge sys_clk) begin
        if (do_wr) mem[wr_ptr[AW-1:0]] <= in_data;
    end
endmodule

module emac_ctl
    import emac_ctl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Software configuration
    input wire logic tx_full_duplex,
    input wire logic tx_auto_fcs,
    input wire logic tx_pad_short_frames,
    input wire logic rx_accept_bad_fcs,
    input wire logic rx_accept_multicast,
    input wire logic rx_accept_all_frames,
    input wire logic [47:0] station_addr,
    input wire logic ctl_start,
    input wire logic ctl_stop,
    // Software interrupt control
    input wire logic [6:0] irq_enable_wr,
    input wire logic irq_enable_we,
    input wire logic [6:0] irq_clear,
    // Events from MAC engines and PHY
    input wire logic phy_irq_pin,
    input wire logic mgmt_done,
    input wire logic rx_len_err,
    input wire logic rx_phy_err,
    input wire logic tx_sent,
    input wire logic tx_retry_fail,
    input wire logic tx_len_bad,
    // Receive byte stream from MAC
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_valid,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic rx_fcs_ok,
    input wire logic [11:0] rx_frame_len,
    output logic rx_byte_ready,
    // Receive FIFO read side
    output rx_word_t rd_word,
    output logic rd_valid,
    input wire logic rd_ready,
    // Status and controls to engines
    output tx_cfg_t tx_cfg,
    output rx_cfg_t rx_cfg,
    output logic tx_on,
    output logic rx_on,
    output logic [6:0] irq_raw,
    output logic [6:0] irq_masked,
    output logic [6:0] irq_mask,
    output logic [4:0] rx_pkt_count,
    output logic irq_out
);
    rx_state_t state;
    rx_state_t next_state;
    logic phy_s1;
    logic phy_s2;
    logic phy_s3;
    logic [47:0] dest;
    logic [2:0] dest_idx;
    logic fifo_in_ready;
    logic fifo_valid;
    rx_word_t fifo_word;
    logic [4:0] fifo_free;
    logic [6:0] next_raw;
    logic [6:0] event_set;
    logic [4:0] next_count;

    // Options are registered straight through, each independent
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_cfg <= '0;
            rx_cfg <= '0;
        end else begin
            tx_cfg <= '{tx_full_duplex, tx_auto_fcs,
                        tx_pad_short_frames};
            rx_cfg <= '{rx_accept_bad_fcs, rx_accept_multicast,
                        rx_accept_all_frames};
        end
    end

    // Start and stop; stop wins if both arrive together
    always_ff @(posedge sys_clk) begin
        if (srst || ctl_stop) begin
            tx_on <= 1'b0;
            rx_on <= 1'b0;
        end else if (ctl_start) begin
            tx_on <= 1'b1;
            rx_on <= 1'b1;
        end
    end

    // PHY interrupt pin is asynchronous: two flops, then edge detect
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            phy_s1 <= 1'b0;
            phy_s2 <= 1'b0;
            phy_s3 <= 1'b0;
        end else begin
            phy_s1 <= phy_irq_pin;
            phy_s2 <= phy_s1;
            phy_s3 <= phy_s2;
        end
    end

    // Receive filter: collect the destination, then pass or drop
    wire fifo_flush = ctl_stop || ctl_start;
    wire byte_in = rx_byte_valid && rx_byte_ready;
    wire dest_done = (dest_idx == 3'h6);
    wire is_mcast = dest[MCAST_BIT];
    wire addr_hit = (dest == station_addr);
    wire frame_ok = rx_fcs_ok || rx_cfg.accept_bad_fcs;
    wire accept = rx_cfg.accept_all || addr_hit ||
                  (is_mcast && rx_cfg.accept_multicast);
    wire too_big = rx_sof && rx_on &&
                   ({7'h00, fifo_free} < rx_frame_len);
    // Count follows the stored last flag, so every counted frame is
    // also the one a reader later pops with last set
    wire pkt_in = byte_in && rx_eof && state == ST_PASS &&
                  frame_ok;
    wire pkt_out = fifo_valid && rd_ready && fifo_word.last;

    // Dropping also drains bytes so the MAC never stalls on them
    assign rx_byte_ready = (state == ST_DROP) || !rx_on ||
                           (state == ST_PASS && fifo_in_ready) ||
                           (state == ST_IDLE && !dest_done);
    assign next_state = !rx_on ? ST_IDLE :
        (byte_in && rx_eof) ? ST_IDLE :
        (state == ST_IDLE && rx_sof && too_big) ? ST_DROP :
        (state == ST_IDLE && dest_done) ?
            (accept ? ST_PASS : ST_DROP) : state;

    // Destination octets arrive first, lowest octet in low bits
    always_ff @(posedge sys_clk) begin
        if (srst || (byte_in && rx_eof) || !rx_on) begin
            state <= ST_IDLE;
            dest_idx <= 3'h0;
            dest <= '0;
        end else begin
            state <= next_state;
            if (byte_in && state == ST_IDLE && !dest_done) begin
                dest[dest_idx*8 +: 8] <= rx_byte;
                dest_idx <= dest_idx + 3'h1;
            end
        end
    end

    // Address bytes stay in the filter register and are not replayed:
    // only bytes after the destination are stored in the FIFO.
    emac_fifo #(.WIDTH(RX_WIDTH), .DEPTH(RX_DEPTH)) u_rx_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .flush(fifo_flush),
        .in_data({rx_eof && frame_ok, rx_byte}),
        .in_valid(rx_byte_valid && state == ST_PASS),
        .in_ready(fifo_in_ready),
        .out_data(fifo_word),
        .out_valid(fifo_valid),
        .out_ready(rd_ready),
        .free(fifo_free)
    );

    // Packet count follows completed frames in and out
    assign next_count = fifo_flush ? PKT_CNT_RST :
        rx_pkt_count + {4'h0, pkt_in} - {4'h0, pkt_out};

    // Event sources into the sticky raw bits
    assign event_set[IRQ_PHY] = phy_s2 && !phy_s3;
    assign event_set[IRQ_MGMT] = mgmt_done;
    assign event_set[IRQ_RXER] = byte_in && rx_eof &&
        (!rx_fcs_ok || rx_len_err || rx_phy_err);
    assign event_set[IRQ_RXOF] = too_big;
    assign event_set[IRQ_TX] = tx_sent;
    assign event_set[IRQ_TXER] = tx_retry_fail || tx_len_bad;
    assign event_set[IRQ_RX] = (next_count != PKT_CNT_RST);

    // Set beats clear in the same cycle, so no event is lost
    // Receive available is a level that follows the count, not latched
    wire [6:0] sticky_raw = (irq_raw & ~irq_clear) | event_set;
    wire [6:0] level_sel = 7'(1 << IRQ_RX);
    assign next_raw = (sticky_raw & ~level_sel) |
                      (event_set & level_sel);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_raw <= IRQ_RAW_RST;
            irq_mask <= IRQ_MASK_RST;
            rx_pkt_count <= PKT_CNT_RST;
        end else begin
            irq_raw <= next_raw;
            rx_pkt_count <= next_count;
            if (irq_enable_we) irq_mask <= irq_enable_wr;
        end
    end

    // Masked view and line are registered from the next raw bits and the next mask
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_masked <= IRQ_RAW_RST;
            irq_out <= 1'b0;
        end else begin
            irq_masked <= next_raw & (irq_enable_we ? irq_enable_wr
                                                    : irq_mask);
            irq_out <= |(next_raw & (irq_enable_we ? irq_enable_wr
                                                   : irq_mask));
        end
    end

    assign rd_word = fifo_word;
    assign rd_valid = fifo_valid;

    a_stop_off: assert property (@(posedge sys_clk) disable iff (srst)
        ctl_stop |=> !tx_on && !rx_on && !rd_valid)
        else $error("stop did not disable engines");
    a_start_on: assert property (@(posedge sys_clk) disable iff (srst)
        ctl_start && !ctl_stop |=> tx_on && rx_on && !rd_valid)
        else $error("start did not enable engines");
    a_clear_exact: assert property (@(posedge sys_clk) disable iff (srst)
        irq_clear[IRQ_TX] && !tx_sent |=> !irq_raw[IRQ_TX])
        else $error("cleared source still pending");
    a_line_masked: assert property (@(posedge sys_clk) disable iff (srst)
        irq_out == |irq_masked)
        else $error("line disagrees with masked view");
    a_view_same: assert property (@(posedge sys_clk) disable iff (srst)
        (irq_masked & ~irq_raw) == 7'h00)
        else $error("masked bit without raw bit");
    a_phy_edge: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(phy_s2) |=> irq_raw[IRQ_PHY])
        else $error("phy event not latched");
    a_mgmt_set: assert property (@(posedge sys_clk) disable iff (srst)
        mgmt_done |=> irq_raw[IRQ_MGMT])
        else $error("management done not latched");
    a_tx_err: assert property (@(posedge sys_clk) disable iff (srst)
        tx_retry_fail || tx_len_bad |=> irq_raw[IRQ_TXER])
        else $error("transmit error not latched");
    a_raw_sticky: assert property (@(posedge sys_clk) disable iff (srst)
        irq_raw[IRQ_TX] && !irq_clear[IRQ_TX] |=> irq_raw[IRQ_TX])
        else $error("raw bit dropped without clear");
    a_rx_avail: assert property (@(posedge sys_clk) disable iff (srst)
        irq_raw[IRQ_RX] || rx_pkt_count == 5'h00)
        else $error("frames waiting without available flag");
endmodule

/* verilog/emac_ctl_pkg.sv */
// Package for the MAC control and interrupt block: field positions,
// reset values, enumerations and carrier structs shared by its modules.
package emac_ctl_pkg;

    // Interrupt source bit positions, shared by raw and masked views
    localparam int IRQ_PHY = 0;
    localparam int IRQ_MGMT = 1;
    localparam int IRQ_RXER = 2;
    localparam int IRQ_RXOF = 3;
    localparam int IRQ_TX = 4;
    localparam int IRQ_TXER = 5;
    localparam int IRQ_RX = 6;
    localparam int IRQ_COUNT = 7;

    // Reset values
    localparam logic [6:0] IRQ_MASK_RST = 7'h00;
    localparam logic [6:0] IRQ_RAW_RST = 7'h00;

    // Receive FIFO shape and packet counter width
    localparam int RX_WIDTH = 9;
    localparam int RX_DEPTH = 16;
    localparam int PKT_CNT_W = 5;
    localparam logic [4:0] PKT_CNT_RST = 5'h00;

    // Multicast marker: least significant bit of the first address octet
    localparam int MCAST_BIT = 0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PASS = 3'b010,
        ST_DROP = 3'b100
    } rx_state_t;

    // Transmit options
    typedef struct packed {
        logic full_duplex;
        logic auto_fcs;
        logic pad_short;
    } tx_cfg_t;

    // Receive options
    typedef struct packed {
        logic accept_bad_fcs;
        logic accept_multicast;
        logic accept_all;
    } rx_cfg_t;

    // One receive FIFO word: byte plus end-of-frame marker
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } rx_word_t;

endpackage

/* tb/phy_link_model.sv */
// Link side model: delivers received frames as a byte stream.
// Assumes sys_clk is shared and send is called just after a rising edge.
`timescale 1ns/1ps
module phy_link_model (
    // Clock and flow control
    input wire logic sys_clk,
    input wire logic rx_byte_ready,
    // Byte stream toward the MAC
    output logic [7:0] rx_byte,
    output logic rx_byte_valid,
    output logic rx_sof,
    output logic rx_eof,
    output logic rx_fcs_ok,
    output logic rx_len_err,
    output logic [11:0] rx_frame_len
);
    initial begin
        {rx_byte, rx_byte_valid, rx_sof, rx_eof} = 11'h000;
        {rx_fcs_ok, rx_len_err, rx_frame_len} = 14'h0000;
    end

    // Destination octets first, then payload A0+i; each byte held until
    // ready, and the bus shows the inverted byte once released
    task automatic send(input logic [47:0] dest, input logic [11:0] len,
                        input logic fcs, input logic lerr);
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            b = (i < 6) ? dest[8*i +: 8] : 8'hA0 + 8'(i);
            rx_byte <= b;
            rx_byte_valid <= 1'b1;
            rx_sof <= (i == 0);
            rx_eof <= (i == 7);
            rx_fcs_ok <= fcs;
            rx_len_err <= lerr;
            rx_frame_len <= len;
            #1;
            while (!rx_byte_ready) begin
                @(posedge sys_clk);
                #1;
            end
            @(posedge sys_clk);
        end
        rx_byte <= ~b;
        {rx_byte_valid, rx_sof, rx_eof} <= 3'h0;
    endtask
endmodule

/* tb/tb.sv */
// Bench for the MAC control block: option and event table, then frame,
// filter, mask, PHY pin and start/stop cases.
// Assumes phy_link_model on the receive stream and a 10 MHz sys_clk.
`timescale 1ns/1ps
module tb;
    import emac_ctl_pkg::*;
    typedef struct packed {
        logic [5:0] cfg;
        logic [3:0] ev;
        logic [6:0] raw;
    } row_t;
    typedef struct packed {
        logic [47:0] dest;
        logic [11:0] len;
        logic fcs;
        logic lerr;
        logic [5:0] cfg;
        logic [6:0] raw;
        logic [4:0] cnt;
    } frm_t;
    localparam logic [47:0] STA = 48'h800000_48DEAC;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] cfg = 6'h00;
    logic [3:0] ev = 4'h0;
    logic start = 1'b0;
    logic stop = 1'b0;
    logic phy_pin = 1'b0;
    logic [6:0] en_wr = 7'h00;
    logic en_we = 1'b0;
    logic [6:0] clr = 7'h00;
    logic rd_ready = 1'b0;
    logic [7:0] rx_byte;
    logic [11:0] flen;
    logic bvalid, sof, eof, fcs_ok, len_err, bready, rd_valid;
    logic tx_on, rx_on, irq_out;
    logic [6:0] raw, masked, mask;
    logic [4:0] cnt;
    rx_word_t rd_word;
    tx_cfg_t tx_cfg;
    rx_cfg_t rx_cfg;
    int n_mismatch = 0;
    int checked = 0;
    row_t rows [6] = '{{6'h20, 4'h1, 7'h02}, {6'h10, 4'h2, 7'h10},
        {6'h08, 4'h4, 7'h20}, {6'h04, 4'h8, 7'h20},
        {6'h02, 4'h0, 7'h00}, {6'h01, 4'h3, 7'h12}};
    frm_t frms [7] = '{{48'h01, 12'd8, 1'b1, 1'b0, 6'h00, 7'h00, 5'h0},
        {48'h01, 12'd8, 1'b1, 1'b0, 6'h02, 7'h40, 5'h1},
        {48'h02, 12'd8, 1'b1, 1'b0, 6'h00, 7'h40, 5'h1},
        {48'h02, 12'd8, 1'b1, 1'b0, 6'h01, 7'h40, 5'h2},
        {STA, 12'd100, 1'b1, 1'b0, 6'h00, 7'h48, 5'h2},
        {STA, 12'd8, 1'b0, 1'b0, 6'h00, 7'h44, 5'h2},
        {STA, 12'd8, 1'b1, 1'b1, 6'h00, 7'h44, 5'h3}};

    emac_ctl i_emac_ctl (.sys_clk(sys_clk), .srst(srst),
        .tx_full_duplex(cfg[5]), .tx_auto_fcs(cfg[4]),
        .tx_pad_short_frames(cfg[3]), .rx_accept_bad_fcs(cfg[2]),
        .rx_accept_multicast(cfg[1]), .rx_accept_all_frames(cfg[0]),
        .station_addr(STA), .ctl_start(start), .ctl_stop(stop),
        .irq_enable_wr(en_wr), .irq_enable_we(en_we), .irq_clear(clr),
        .phy_irq_pin(phy_pin), .mgmt_done(ev[0]), .rx_len_err(len_err),
        .rx_phy_err(1'b0), .tx_sent(ev[1]), .tx_retry_fail(ev[2]),
        .tx_len_bad(ev[3]), .rx_byte(rx_byte), .rx_byte_valid(bvalid),
        .rx_sof(sof), .rx_eof(eof), .rx_fcs_ok(fcs_ok),
        .rx_frame_len(flen), .rx_byte_ready(bready), .rd_word(rd_word),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .tx_cfg(tx_cfg),
        .rx_cfg(rx_cfg), .tx_on(tx_on), .rx_on(rx_on), .irq_raw(raw),
        .irq_masked(masked), .irq_mask(mask), .rx_pkt_count(cnt),
        .irq_out(irq_out));
    phy_link_model i_phy_link_model (.sys_clk(sys_clk),
        .rx_byte_ready(bready), .rx_byte(rx_byte), .rx_byte_valid(bvalid),
        .rx_sof(sof), .rx_eof(eof), .rx_fcs_ok(fcs_ok),
        .rx_len_err(len_err), .rx_frame_len(flen));

    // 100 ns period
    always #50 sys_clk = ~sys_clk;

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic results;
        if (n_mismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence; each table row's pending sources are cleared right after its check
    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        settle(1);
        chk({tx_on, rx_on, raw, masked, mask, cnt, irq_out}, 0);
        chk(bready, 1'b1);
        foreach (rows[i]) begin
            @(posedge sys_clk);
            cfg <= rows[i].cfg;
            ev <= rows[i].ev;
            @(posedge sys_clk);
            ev <= 4'h0;
            #1;
            chk({tx_cfg, rx_cfg}, rows[i].cfg);
            chk(raw, rows[i].raw);
            chk({masked, irq_out}, 0);
            @(posedge sys_clk);
            clr <= rows[i].raw;
            @(posedge sys_clk);
            clr <= 7'h00;
            #1;
            chk(raw, 7'h00);
        end
        // Mask one source, clear one of two, clear racing a new event
        @(posedge sys_clk);
        {en_wr, en_we, ev} <= {7'h02, 1'b1, 4'h3};
        @(posedge sys_clk);
        {en_we, ev, clr} <= {1'b0, 4'h0, 7'h02};
        #1;
        chk({mask, masked, irq_out}, {7'h02, 7'h02, 1'b1});
        @(posedge sys_clk);
        {clr, ev} <= {7'h10, 4'h2};
        #1;
        chk({raw, irq_out}, {7'h10, 1'b0});
        @(posedge sys_clk);
        {clr, ev, en_wr, en_we, phy_pin} <= {7'h00, 4'h0, 7'h7F, 2'h3};
        #1;
        chk(raw, 7'h10);
        settle(3);
        chk({raw, masked, irq_out}, {7'h11, 7'h11, 1'b1});
        @(posedge sys_clk);
        {clr, en_we, phy_pin, cfg, start} <= {7'h7F, 2'h0, 6'h00, 1'b1};
        @(posedge sys_clk);
        {clr, start} <= 8'h00;
        #1;
        chk({tx_on, rx_on, raw, cnt}, {2'b11, 12'h000});
        @(posedge sys_clk);
        i_phy_link_model.send(STA, 12'd8, 1'b1, 1'b0);
        settle(1);
        chk({cnt, raw, irq_out}, {5'h1, 7'h40, 1'b1});
        @(posedge sys_clk);
        rd_ready <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            #1;
            chk({rd_valid, rd_word}, {1'b1, k == 1, 8'hA6 + 8'(k)});
            @(posedge sys_clk);
        end
        rd_ready <= 1'b0;
        settle(1);
        chk({cnt, raw}, 12'h000);
        foreach (frms[i]) begin
            @(posedge sys_clk);
            cfg <= frms[i].cfg;
            @(posedge sys_clk);
            i_phy_link_model.send(frms[i].dest, frms[i].len, frms[i].fcs,
                                  frms[i].lerr);
            settle(1);
            chk({cnt, raw}, {frms[i].cnt, frms[i].raw});
            @(posedge sys_clk);
            clr <= 7'h3F;
            @(posedge sys_clk);
            clr <= 7'h00;
        end
        // Stop with frames pending; later bytes must be dropped
        @(posedge sys_clk);
        stop <= 1'b1;
        @(posedge sys_clk);
        stop <= 1'b0;
        #1;
        chk({tx_on, rx_on, cnt, rd_valid}, 0);
        @(posedge sys_clk);
        i_phy_link_model.send(STA, 12'd8, 1'b1, 1'b0);
        settle(1);
        chk({cnt, rd_valid}, 0);
        results();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        results();
    end
endmodule
